// *** inc/epc_defines.vh ***
// constants for the eeprom program/erase controller
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define EPC_ARR_BASE 16'h0800
`define EPC_ARR_MASK 16'hFE00
`define EPC_ARR_SIZE 512
`define EPC_CTRL_IDX 16'hFE1D
`define EPC_NVCFG_IDX 16'hFE1C
`define EPC_SHADOW_IDX 16'hFE1E

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define EPC_CTL_HV 0
`define EPC_CTL_LAT 2
`define EPC_CTL_ERLO 3
`define EPC_CTL_ERHI 4

// ------------------------------------------------------------
// configuration byte fields
// ------------------------------------------------------------
`define EPC_CFG_BP_HI 3
`define EPC_CFG_RED 4

// ------------------------------------------------------------
// modes and values
// ------------------------------------------------------------
`define EPC_MODE_PROG 2'b00
`define EPC_MODE_BYTE 2'b01
`define EPC_MODE_BLOCK 2'b10
`define EPC_MODE_BULK 2'b11
`define EPC_ERASED 8'hFF
`define EPC_NVCFG_INIT 8'h00
`define EPC_SHADOW_RST 5'h00
`define EPC_BLK_FIRST 7'h00
`define EPC_BLK_LAST 7'h7F
`define EPC_ARR_FIRST 9'h000
`define EPC_ARR_LAST 9'h1FF

`endif

// *** sim/epc_ctrl_sva.sv ***
// assertion checker for the eeprom program/erase controller
`timescale 1ns/1ns
`default_nettype none
module epc_ctrl_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pump_on
);
  wire logic [15:0] idx = paddr[17:2];
  wire logic setup = psel && !penable;
  wire logic mapped = (idx[15:9] == 7'h04) || (idx >= 16'hFE1C && idx <= 16'hFE1E);
  wire logic ctl_wr = psel && penable && pready && pwrite && idx == 16'hFE1D;
  wire logic hv_wr = ctl_wr && pwdata[0];
  wire logic hv_clr = ctl_wr && !pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACK_NEXT: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_ACK_ONCE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ACK_CAUSE: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  AST_ERR_ACK: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  AST_UNMAPPED: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped index accepted");
  AST_LOWER_OK: assert property (setup && idx[15:8] == 8'h08 |=> !pslverr)
    else $error("lower half refused");
  AST_PUMP_CAUSE: assert property ($rose(pump_on) |->
    $past(hv_wr, 2) || $past(hv_wr, 3) || $past(hv_wr, 4))
    else $error("pump started without enable write");
  AST_PUMP_DROP: assert property (hv_clr && pump_on |-> ##[1:3] !pump_on)
    else $error("pump kept after enable clear");
  AST_PUMP_STOP: assert property ($fell(pump_on) |->
    $past(hv_clr, 1) || $past(hv_clr, 2) || $past(hv_clr, 3))
    else $error("pump stopped without enable clear");
endmodule // epc_ctrl_sva
bind epc_eeprom_ctrl epc_ctrl_sva i_epc_ctrl_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_on(pump_on));
`default_nettype wire

// *** sim/epc_host.sv ***
// host cpu model issuing apb transfers to the controller
`timescale 1ns/1ns
`default_nettype none
module epc_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [17:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [7:0] rdat;
  logic rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
  end
  // one transfer, entered just after a rising edge
  task xfer(input logic w, input logic [15:0] i, input logic [7:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata[7:0];
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task op(input logic [1:0] m, input logic [15:0] i, input logic [7:0] d);
    begin
      xfer(1'b1, 16'hFE1D, {3'b000, m, 3'b100});
      xfer(1'b1, i, d);
      xfer(1'b1, 16'hFE1D, {3'b000, m, 3'b101});
      repeat (600) @(posedge pclk);
      xfer(1'b1, 16'hFE1D, {3'b000, m, 3'b100});
      repeat (4) @(posedge pclk);
      xfer(1'b1, 16'hFE1D, 8'h00);
    end
  endtask
endmodule // epc_host
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the eeprom program/erase controller
`timescale 1ns/1ns
`default_nettype none
`include "epc_defines.vh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  wire logic psel, penable, pwrite, pready, pslverr, pump_on;
  wire logic [17:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int error_cnt = 0;
  int check_count = 0;
  localparam logic [15:0] CT = `EPC_CTRL_IDX;
  localparam logic [15:0] NV = `EPC_NVCFG_IDX;
  localparam logic [15:0] SH = `EPC_SHADOW_IDX;
  always #5 pclk = ~pclk;
  epc_eeprom_ctrl i_epc_eeprom_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_on(pump_on));
  epc_host i_epc_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task dc(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
      check_count++;
      if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task fc(input string n, input logic e, input logic g);
    begin
      check_count++;
      if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s exp %b got %b", n, e, g);
      end
    end
  endtask
  task rc(input logic [15:0] i, input logic [7:0] e);
    begin
      i_epc_host.xfer(1'b0, i, 8'h00);
      dc("read data", e, i_epc_host.rdat);
    end
  endtask
  task ec(input logic [15:0] i, input logic e);
    begin
      i_epc_host.xfer(1'b0, i, 8'h00);
      fc("slave error", e, i_epc_host.rerr);
    end
  endtask
  task w(input logic [15:0] i, input logic [7:0] d);
    i_epc_host.xfer(1'b1, i, d);
  endtask
  task p(input logic [1:0] m, input logic [15:0] i, input logic [7:0] d);
    i_epc_host.op(m, i, d);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rc(16'h0800, 8'hFF);
    rc(CT, 8'h00);
    ec(16'h0400, 1'b1);
    ec(16'h09FF, 1'b0);
    $display("test reset done");
    p(2'b00, 16'h0805, 8'hA5);
    rc(16'h0805, 8'hA5);
    p(2'b00, 16'h0805, 8'h5A);
    rc(16'h0805, 8'h00);
    p(2'b01, 16'h0805, 8'h00);
    rc(16'h0805, 8'hFF);
    p(2'b00, 16'h0880, 8'h00);
    p(2'b00, 16'h08FF, 8'h00);
    p(2'b00, 16'h0805, 8'h11);
    p(2'b10, 16'h08C0, 8'h00);
    rc(16'h0880, 8'hFF);
    rc(16'h08FF, 8'hFF);
    rc(16'h0805, 8'h11);
    p(2'b11, 16'h09A0, 8'h00);
    rc(16'h0805, 8'hFF);
    rc(NV, 8'h00);
    $display("test program erase done");
    w(CT, 8'h04);
    w(CT, 8'h1C);
    rc(CT, 8'h04);
    w(16'h0810, 8'h3C);
    w(16'h0400, 8'h00);
    rc(16'h0820, 8'h3C);
    w(16'h0811, 8'hC3);
    rc(16'h0820, 8'hC3);
    w(CT, 8'h05);
    repeat (3) @(posedge pclk);
    fc("pump", 1'b1, pump_on);
    w(CT, 8'h1D);
    rc(CT, 8'h05);
    w(CT, 8'h00);
    rc(CT, 8'h04);
    fc("pump", 1'b0, pump_on);
    w(CT, 8'h00);
    w(16'h0400, 8'h00);
    w(CT, 8'h01);
    rc(CT, 8'h00);
    $display("test latch done");
    p(2'b01, NV, 8'h00);
    p(2'b00, NV, 8'h01);
    rc(NV, 8'h01);
    rc(SH, 8'h01);
    p(2'b00, 16'h0806, 8'h00);
    rc(16'h0806, 8'hFF);
    p(2'b11, 16'h0880, 8'h00);
    rc(16'h0811, 8'hC3);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rc(SH, 8'h01);
    $display("test protection done");
    p(2'b01, NV, 8'h00);
    p(2'b00, NV, 8'h1C);
    rc(NV, 8'h1C);
    ec(16'h0930, 1'b1);
    p(2'b00, 16'h0830, 8'h66);
    rc(16'h0830, 8'h66);
    p(2'b00, NV, 8'h00);
    rc(NV, 8'h00);
    rc(16'h0930, 8'h66);
    $display("test redundant done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire

// *** verilog/epc_eeprom_ctrl.v ***
// eeprom program/erase controller with apb register access
`timescale 1ns/1ns
`default_nettype none
`include "epc_defines.vh"
// How it works
// - 512-byte array at 0x0800 to 0x09FF
// - erased reads one; program only clears bits
// - only unprotected array bytes or config change
// - redundant mode acts on both twin bytes
// - redundant mode ignores upper half, bp3/bp2
// - both erase selects zero means program
// - select 00/01/10/11 program/byte/block/bulk
// - latch captures only valid array or config writes
// - latched array reads return captured data byte
// - latched control writes need prior capture
// - no high voltage without latch and capture
// - high voltage bit drives the pump
// - clearing both bits with voltage on clears only voltage
// - mode frozen while high voltage set
// - block and bulk erase whole range
// - block and bulk spare config byte
// - four 128-byte blocks, protect bits ascending
// - protected target gets no voltage
// - any protect bit blocks bulk erase
// - shadow reloads at reset and config read
// - config byte survives reset

module epc_eeprom_ctrl #(
  parameter [7:0] NVCFG_INIT = `EPC_NVCFG_INIT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg pump_on
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [7:0] mem [0:`EPC_ARR_SIZE-1];
  reg [7:0] nvcfg_reg;
  reg [4:0] shadow_reg;
  reg load_pend_reg;
  reg hv_reg;
  reg lat_reg;
  reg [1:0] mode_reg;
  reg cap_valid_reg;
  reg cap_cfg_reg;
  reg [8:0] cap_addr_reg;
  reg [7:0] cap_data_reg;
  reg [1:0] state_reg;
  reg [8:0] cnt_reg;
  reg [8:0] last_reg;
  reg op_ok_reg;

  integer i;

  // erased array at power-up
  initial begin
    for (i = 0; i < `EPC_ARR_SIZE; i = i + 1) begin
      mem[i] = `EPC_ERASED;
    end
    nvcfg_reg = NVCFG_INIT;
  end

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function is_arr;
    input [15:0] idx;
    begin
      is_arr = ((idx & `EPC_ARR_MASK) == `EPC_ARR_BASE);
    end
  endfunction

  // protection of one array byte under a configuration
  // block number from address bits
  function prot;
    input [8:0] a;
    input [4:0] c;
    reg [1:0] b;
    begin
      b = c[`EPC_CFG_RED] ? {1'b0, a[7]} : a[8:7];
      prot = c[b];
    end
  endfunction

  function any_prot;
    input [4:0] c;
    begin
      if (c[`EPC_CFG_RED]) begin
        any_prot = |c[1:0];
      end else begin
        any_prot = |c[`EPC_CFG_BP_HI:0];
      end
    end
  endfunction

  // program clears bits, erase sets all
  function [7:0] cell_next;
    input [7:0] old;
    input [7:0] dat;
    input pgm;
    begin
      cell_next = pgm ? (old & dat) : `EPC_ERASED;
    end
  endfunction

  function [8:0] twin_of;
    input [8:0] a;
    begin
      twin_of = {1'b1, a[7:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire [15:0] idx = paddr[17:2];
  wire red = shadow_reg[`EPC_CFG_RED];
  wire [8:0] off = idx[8:0];
  wire arr_raw = is_arr(idx);
  wire arr_hit = arr_raw && !(red && off[8]);
  wire cfg_hit = (idx == `EPC_NVCFG_IDX);
  wire ctl_hit = (idx == `EPC_CTRL_IDX);
  wire shd_hit = (idx == `EPC_SHADOW_IDX);
  wire mapped = arr_hit || cfg_hit || ctl_hit || shd_hit;
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire [8:0] twin = twin_of(cnt_reg);
  wire ctl_wr = wr && ctl_hit;
  // latched control writes wait for a capture
  wire ctl_ok = !lat_reg || cap_valid_reg;
  wire want_hv = pwdata[`EPC_CTL_HV];
  // voltage refused without latch and capture
  // latch must stand from an earlier write
  wire hv_start = ctl_wr && ctl_ok && want_hv && !hv_reg && lat_reg && cap_valid_reg;

  // ------------------------------------------------------------
  // operation window and permission
  // ------------------------------------------------------------
  reg [8:0] first_c;
  reg [8:0] last_c;
  reg ok_c;

  always @* begin
    first_c = cap_addr_reg;
    last_c = cap_addr_reg;
    ok_c = 1'b0;
    case (mode_reg)
      `EPC_MODE_PROG: begin
        ok_c = cap_cfg_reg || !prot(cap_addr_reg, shadow_reg);
      end
      `EPC_MODE_BYTE: begin
        ok_c = cap_cfg_reg || !prot(cap_addr_reg, shadow_reg);
      end
      `EPC_MODE_BLOCK: begin
        first_c = {cap_addr_reg[8:7], `EPC_BLK_FIRST};
        last_c = {cap_addr_reg[8:7], `EPC_BLK_LAST};
        ok_c = !cap_cfg_reg && !prot(cap_addr_reg, shadow_reg);
      end
      `EPC_MODE_BULK: begin
        first_c = `EPC_ARR_FIRST;
        last_c = `EPC_ARR_LAST;
        // any protect bit stops bulk erase
        ok_c = !cap_cfg_reg && !any_prot(shadow_reg);
      end
      default: begin
        ok_c = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // control register and capture
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_reg <= 1'b0;
      lat_reg <= 1'b0;
      mode_reg <= `EPC_MODE_PROG;
      cap_valid_reg <= 1'b0;
      cap_cfg_reg <= 1'b0;
      cap_addr_reg <= `EPC_ARR_FIRST;
      cap_data_reg <= `EPC_ERASED;
    end else begin
      if (ctl_wr && ctl_ok) begin
        // latch held while voltage is on
        if (hv_reg) begin
          lat_reg <= 1'b1;
        end else begin
          lat_reg <= pwdata[`EPC_CTL_LAT];
          if (!pwdata[`EPC_CTL_LAT]) begin
            cap_valid_reg <= 1'b0;
          end
        end
        if (!hv_reg) begin
          mode_reg <= {pwdata[`EPC_CTL_ERHI], pwdata[`EPC_CTL_ERLO]};
        end
        if (!want_hv) begin
          hv_reg <= 1'b0;
        end else if (hv_start) begin
          hv_reg <= 1'b1;
        end
      end
      // latest valid array write replaces capture
      if (wr && lat_reg && !hv_reg && (arr_hit || cfg_hit)) begin
        cap_valid_reg <= 1'b1;
        cap_cfg_reg <= cfg_hit;
        cap_addr_reg <= off;
        cap_data_reg <= pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= `EPC_ARR_FIRST;
      last_reg <= `EPC_ARR_FIRST;
      op_ok_reg <= 1'b0;
      pump_on <= 1'b0;
    end else begin
      pump_on <= hv_reg && op_ok_reg;
      case (state_reg)
        ST_IDLE: begin
          if (hv_start) begin
            cnt_reg <= first_c;
            last_reg <= last_c;
            op_ok_reg <= ok_c;
            state_reg <= ok_c ? ST_RUN : ST_DONE;
          end
        end
        ST_RUN: begin
          if (!hv_reg) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == last_reg) begin
            state_reg <= ST_DONE;
          end else begin
            cnt_reg <= cnt_reg + 9'h001;
          end
        end
        ST_DONE: begin
          if (!hv_reg) begin
            state_reg <= ST_IDLE;
            op_ok_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // nonvolatile cells, no reset
  // ------------------------------------------------------------
  wire run = (state_reg == ST_RUN) && hv_reg;
  wire prog = (mode_reg == `EPC_MODE_PROG);

  always @(posedge pclk) begin
    if (run) begin
      // config byte changes only like an array byte
      if (cap_cfg_reg) begin
        nvcfg_reg <= cell_next(nvcfg_reg, cap_data_reg, prog);
      end else if (!prot(cnt_reg, shadow_reg)) begin
        mem[cnt_reg] <= cell_next(mem[cnt_reg], cap_data_reg, prog);
        if (red && !cnt_reg[8]) begin
          mem[twin] <= cell_next(mem[twin], cap_data_reg, prog);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // configuration shadow
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_reg <= `EPC_SHADOW_RST;
      load_pend_reg <= 1'b1;
    end else begin
      // reload after reset and on config read
      if (load_pend_reg || (rd && cfg_hit)) begin
        shadow_reg <= nvcfg_reg[`EPC_CFG_RED:0];
        load_pend_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // apb read data and response
  // ------------------------------------------------------------
  reg [31:0] rdata_c;

  always @* begin
    rdata_c = 32'h0000_0000;
    if (ctl_hit) begin
      rdata_c[`EPC_CTL_HV] = hv_reg;
      rdata_c[`EPC_CTL_LAT] = lat_reg;
      rdata_c[`EPC_CTL_ERLO] = mode_reg[0];
      rdata_c[`EPC_CTL_ERHI] = mode_reg[1];
    end else if (cfg_hit) begin
      rdata_c[7:0] = nvcfg_reg;
    end else if (shd_hit) begin
      rdata_c[4:0] = shadow_reg;
    end else if (arr_hit) begin
      if (lat_reg) begin
        rdata_c[7:0] = cap_data_reg;
      end else if (red) begin
        rdata_c[7:0] = mem[off] & mem[twin_of(off)];
      end else begin
        rdata_c[7:0] = mem[off];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_c;
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // epc_eeprom_ctrl
`default_nettype wire
